// ==== hdl/ufc_cfg.svh ====
// Offsets, field positions, ident codes, reset value and level shift of the flow control block
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH
`define UFC_OFS_EFR     6'h00
`define UFC_OFS_TCR     6'h04
`define UFC_OFS_MCR     6'h08
`define UFC_OFS_IER     6'h0c
`define UFC_OFS_IIR     6'h10
`define UFC_OFS_RES1    6'h14
`define UFC_OFS_RES2    6'h18
`define UFC_OFS_HALT1   6'h1c
`define UFC_OFS_HALT2   6'h20
`define UFC_OFS_FMT     6'h24
`define UFC_OFS_STAT    6'h28
`define UFC_EFR_ACTS    7
`define UFC_EFR_ARTS    6
`define UFC_EFR_SPEC    5
`define UFC_MCR_ANY     5
`define UFC_MCR_RTS     1
`define UFC_IER_HALT    5
`define UFC_IER_CTS     7
`define UFC_IIR_NONE    8'h01
`define UFC_IIR_HALT    8'h10
`define UFC_IIR_CTS     8'h20
`define UFC_FMT_RST     8'h03
`define UFC_LVL_SHIFT   2
`endif

// ==== hdl/ufc_pkg.sv ====
// Types shared by the flow control block
package ufc_pkg;
  typedef enum logic [1:0] {
    UFC_IDLE   = 2'b00,
    UFC_FIRST  = 2'b01,
    UFC_SECOND = 2'b10
  } ufc_seq_t;

  typedef struct packed {
    logic        cts_meta;
    logic        cts_sync;
    logic        cts_prev;
    logic [7:0]  enhanced_feature_reg;
    logic [7:0]  flow_threshold_reg;
    logic [7:0]  modem_control_reg;
    logic [7:0]  interrupt_enable_reg;
    logic [7:0]  fmt;
    logic [7:0]  res1;
    logic [7:0]  res2;
    logic [7:0]  halt1;
    logic [7:0]  halt2;
    logic        halted;
    logic        halt_int;
    logic        cts_int;
    logic        pend_h;
    logic        pend_r;
    logic        sent_halt;
    logic        rts_act;
    ufc_seq_t    fseq;
    logic        fkind;
    logic        wait_n;
    logic [31:0] rdata;
    logic        rts_n;
    logic        tx_start;
    logic [7:0]  tx_char;
    logic        tx_pop;
    logic        rx_store;
    logic        irq;
  } ufc_state_t;
endpackage : ufc_pkg

// ==== hdl/ufc_flow.sv ====
// One channel of UART hardware and software flow control with its register slave
//
// Notes on behaviour
// - Auto-CTS and auto-RTS enabled separately by enhanced feature bits 7 and 6.
// - With auto-CTS, no FIFO character starts unless CTS is low; flow characters ignore CTS.
// - With auto-RTS, RTS active below halt level, dropped once it is reached.
// - Dropped RTS comes back when the level falls to the resume level.
// - One more character is still accepted after RTS drops.
// - CTS sampled before each character; character sent whenever CTS active.
// - With auto-CTS on, CTS changes raise no interrupt.
// - With auto-CTS off, characters go regardless of CTS.
// - Feature bits 3:2 pick transmit flow characters: none, second, first, both.
// - Feature bits 1:0 pick receive compare: none, second, first, or either (sequence when bits 3:2 are 0 or 3).
// - Threshold nibbles count in steps of four entries.
// - Any-character resume bit makes any non-halt character after a halt resume.
// - In that mode first resume char resumes; the second is swallowed, not stored.
// - Special detect matches second halt char, flags interrupt, no halt, stored.
// - Special-character interrupt cleared by reading the ident register.
// - Halt character stops transmission after the current character.
// - Halt detection sets ident bit 4 when enabled and raises interrupt.
// - Resume character restarts transmission and clears the halt interrupt.
// - Halt characters sent once receive level reaches the halt threshold.
// - Resume characters sent after a halt when level drops to resume.
// - Flow characters framed as data, trimmed to the word length.
// - Halt interrupt reports code 01 0000, cleared by resume or ident read.
`timescale 1ns/1ps
`include "ufc_cfg.svh"

module ufc_flow
  import ufc_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        cts_n_i,
  output logic             rts_n_o,
  input  wire logic [6:0]  rx_level_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  output logic             rx_store_o,
  input  wire logic        tx_fifo_valid_i,
  input  wire logic [7:0]  tx_fifo_data_i,
  output logic             tx_pop_o,
  input  wire logic        tx_busy_i,
  output logic             tx_start_o,
  output logic [7:0]       tx_char_o,
  output logic             irq_o
);

  ufc_state_t s_ff;
  ufc_state_t nxt_s;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Single character compare against a pair, selected by a two-bit mode
  function automatic logic pair_hit(input logic [7:0] c, input logic [7:0] a,
                                    input logic [7:0] b, input logic [1:0] m);
    pair_hit = (m[1] && (c == a)) || (m[0] && (c == b));
  endfunction : pair_hit

  // Keep only the bits of the configured word length
  function automatic logic [7:0] trim(input logic [7:0] c, input logic [1:0] wl);
    logic [7:0] msk;
    msk = 8'hff >> (2'h3 - wl);
    trim = c & msk;
  endfunction : trim

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic [1:0] txm;
  logic [1:0] rxm;
  logic [6:0] halt_lvl;
  logic [6:0] res_lvl;
  logic       seq_mode;
  logic       is_h;
  logic       is_r;
  logic       cts_ok;
  logic       can_go;
  logic       wr_go;
  logic       rd_go;
  logic [7:0] wbyte;
  logic [7:0] rval;
  logic [7:0] fchar;

  always_comb begin
    nxt_s    = s_ff;
    txm      = s_ff.enhanced_feature_reg[3:2];
    rxm      = s_ff.enhanced_feature_reg[1:0];
    halt_lvl = {1'b0, s_ff.flow_threshold_reg[3:0], 2'b00};
    res_lvl  = {1'b0, s_ff.flow_threshold_reg[7:4], 2'b00};
    seq_mode = (rxm == 2'h3) && ((txm == 2'h3) || (txm == 2'h0));
    is_h     = 1'b0;
    is_r     = 1'b0;
    wbyte    = avs_writedata_i[7:0];
    // Both act at the edge where waitrequest is seen low, as the master expects
    wr_go    = avs_write_i && s_ff.wait_n && avs_byteenable_i[0];
    rd_go    = avs_read_i && s_ff.wait_n;
    rval     = 8'h00;
    fchar    = 8'h00;

    // CTS pin synchroniser; levels from the second stage, edges from the second and third
    nxt_s.cts_meta = cts_n_i;
    nxt_s.cts_sync = s_ff.cts_meta;
    nxt_s.cts_prev = s_ff.cts_sync;
    cts_ok = !s_ff.cts_sync || !s_ff.enhanced_feature_reg[`UFC_EFR_ACTS];

    // Bus handshake: one wait cycle, answer on the next edge
    nxt_s.wait_n = (avs_read_i || avs_write_i) && !s_ff.wait_n;

    // Read data mux, captured as waitrequest drops
    if (avs_address_i == `UFC_OFS_EFR) begin
      rval = s_ff.enhanced_feature_reg;
    end else if (avs_address_i == `UFC_OFS_TCR) begin
      rval = s_ff.flow_threshold_reg;
    end else if (avs_address_i == `UFC_OFS_MCR) begin
      rval = s_ff.modem_control_reg;
    end else if (avs_address_i == `UFC_OFS_IER) begin
      rval = s_ff.interrupt_enable_reg;
    end else if (avs_address_i == `UFC_OFS_IIR) begin
      if (s_ff.halt_int && s_ff.interrupt_enable_reg[`UFC_IER_HALT]) begin
        rval = `UFC_IIR_HALT;
      end else if (s_ff.cts_int && s_ff.interrupt_enable_reg[`UFC_IER_CTS]) begin
        rval = `UFC_IIR_CTS;
      end else begin
        rval = `UFC_IIR_NONE;
      end
    end else if (avs_address_i == `UFC_OFS_RES1) begin
      rval = s_ff.res1;
    end else if (avs_address_i == `UFC_OFS_RES2) begin
      rval = s_ff.res2;
    end else if (avs_address_i == `UFC_OFS_HALT1) begin
      rval = s_ff.halt1;
    end else if (avs_address_i == `UFC_OFS_HALT2) begin
      rval = s_ff.halt2;
    end else if (avs_address_i == `UFC_OFS_FMT) begin
      rval = s_ff.fmt;
    end else if (avs_address_i == `UFC_OFS_STAT) begin
      rval = {4'h0, s_ff.sent_halt, s_ff.rts_act, s_ff.cts_sync, s_ff.halted};
    end else begin
      rval = 8'h00;                                                // Unmapped reads as zero
    end
    if ((avs_read_i || avs_write_i) && !s_ff.wait_n) begin
      nxt_s.rdata = {24'h000000, rval};
    end

    // Register writes take effect at the edge where waitrequest is low
    if (wr_go) begin
      if (avs_address_i == `UFC_OFS_EFR) begin
        nxt_s.enhanced_feature_reg = wbyte;
      end else if (avs_address_i == `UFC_OFS_TCR) begin
        nxt_s.flow_threshold_reg = wbyte;
      end else if (avs_address_i == `UFC_OFS_MCR) begin
        nxt_s.modem_control_reg = wbyte;
      end else if (avs_address_i == `UFC_OFS_IER) begin
        nxt_s.interrupt_enable_reg = wbyte;
      end else if (avs_address_i == `UFC_OFS_RES1) begin
        nxt_s.res1 = wbyte;
      end else if (avs_address_i == `UFC_OFS_RES2) begin
        nxt_s.res2 = wbyte;
      end else if (avs_address_i == `UFC_OFS_HALT1) begin
        nxt_s.halt1 = wbyte;
      end else if (avs_address_i == `UFC_OFS_HALT2) begin
        nxt_s.halt2 = wbyte;
      end else if (avs_address_i == `UFC_OFS_FMT) begin
        nxt_s.fmt = wbyte;
      end
    end

    // Reading the ident register clears pending flags; later sets still win
    if (rd_go && (avs_address_i == `UFC_OFS_IIR)) begin
      nxt_s.halt_int = 1'b0;
      nxt_s.cts_int  = 1'b0;
    end

    // CTS rising to inactive flags an interrupt only without auto-CTS
    if (s_ff.cts_sync && !s_ff.cts_prev && !s_ff.enhanced_feature_reg[`UFC_EFR_ACTS]) begin
      nxt_s.cts_int = 1'b1;
    end

    // Receive side character recognition
    nxt_s.rx_store = 1'b0;
    if (rx_valid_i) begin
      nxt_s.rx_store = 1'b1;
      if (s_ff.enhanced_feature_reg[`UFC_EFR_SPEC] && (rx_data_i == s_ff.halt2)) begin
        nxt_s.halt_int = 1'b1;
      end else begin
        if (seq_mode) begin
          is_h = s_ff.pend_h && (rx_data_i == s_ff.halt2);
          is_r = s_ff.pend_r && (rx_data_i == s_ff.res2);
          nxt_s.pend_h = (rx_data_i == s_ff.halt1);
          nxt_s.pend_r = (rx_data_i == s_ff.res1);
          // Flow characters of the active compare are swallowed
          nxt_s.rx_store = !(pair_hit(rx_data_i, s_ff.halt1, s_ff.halt2, rxm) ||
                             pair_hit(rx_data_i, s_ff.res1, s_ff.res2, rxm));
        end else begin
          is_h = pair_hit(rx_data_i, s_ff.halt1, s_ff.halt2, rxm);
          is_r = pair_hit(rx_data_i, s_ff.res1, s_ff.res2, rxm);
          nxt_s.rx_store = !(is_h || is_r);
        end
        if (s_ff.modem_control_reg[`UFC_MCR_ANY] && s_ff.halted && !is_h) begin
          // Any character resumes; a pending second resume char is no longer taken as a resume
          nxt_s.halted   = 1'b0;
          nxt_s.halt_int = 1'b0;
          nxt_s.pend_r   = 1'b0;
        end else if (is_h) begin
          nxt_s.halted   = 1'b1;
          nxt_s.halt_int = 1'b1;
        end else if (is_r) begin
          nxt_s.halted   = 1'b0;
          nxt_s.halt_int = 1'b0;
        end
      end
    end
    if (rxm == 2'h0) begin
      nxt_s.halted = 1'b0;                                         // Avoids a stuck halt
      nxt_s.pend_h = 1'b0;
      nxt_s.pend_r = 1'b0;
    end

    // Auto-RTS hysteresis; no gating of receive data, so the late char lands
    if (rx_level_i >= halt_lvl) begin
      nxt_s.rts_act = 1'b0;
    end else if (!s_ff.rts_act && (rx_level_i <= res_lvl)) begin
      nxt_s.rts_act = 1'b1;
    end
    if (s_ff.enhanced_feature_reg[`UFC_EFR_ARTS]) begin
      nxt_s.rts_n = !s_ff.rts_act;
    end else begin
      nxt_s.rts_n = !s_ff.modem_control_reg[`UFC_MCR_RTS];
    end

    // Queue halt or resume characters from the receive level
    if (txm == 2'h0) begin
      nxt_s.sent_halt = 1'b0;
    end else if (s_ff.fseq == UFC_IDLE) begin
      if (!s_ff.sent_halt && (rx_level_i >= halt_lvl)) begin
        nxt_s.fseq      = UFC_FIRST;
        nxt_s.fkind     = 1'b1;
        nxt_s.sent_halt = 1'b1;
      end else if (s_ff.sent_halt && (rx_level_i <= res_lvl)) begin
        nxt_s.fseq      = UFC_FIRST;
        nxt_s.fkind     = 1'b0;
        nxt_s.sent_halt = 1'b0;
      end
    end

    // Transmit start: flow characters first, then FIFO data
    nxt_s.tx_start = 1'b0;
    nxt_s.tx_pop   = 1'b0;
    can_go = !tx_busy_i && !s_ff.tx_start;
    if ((s_ff.fseq == UFC_FIRST) && (txm != 2'h1)) begin
      fchar = s_ff.fkind ? s_ff.halt1 : s_ff.res1;
    end else begin
      fchar = s_ff.fkind ? s_ff.halt2 : s_ff.res2;
    end
    if (can_go && (s_ff.fseq != UFC_IDLE)) begin
      nxt_s.tx_start = 1'b1;
      nxt_s.tx_char  = trim(fchar, s_ff.fmt[1:0]);
      if ((s_ff.fseq == UFC_FIRST) && (txm == 2'h3)) begin
        nxt_s.fseq = UFC_SECOND;
      end else begin
        nxt_s.fseq = UFC_IDLE;
      end
    end else if (can_go && tx_fifo_valid_i && !s_ff.halted && cts_ok) begin
      nxt_s.tx_start = 1'b1;
      nxt_s.tx_pop   = 1'b1;
      nxt_s.tx_char  = trim(tx_fifo_data_i, s_ff.fmt[1:0]);
    end

    // Interrupt output from enabled flags
    nxt_s.irq = (nxt_s.halt_int && s_ff.interrupt_enable_reg[`UFC_IER_HALT]) ||
                (nxt_s.cts_int && s_ff.interrupt_enable_reg[`UFC_IER_CTS]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; each channel owns a full copy of this state

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_ff          <= '0;
      s_ff.cts_meta <= 1'b1;
      s_ff.cts_sync <= 1'b1;
      s_ff.cts_prev <= 1'b1;
      s_ff.fmt      <= `UFC_FMT_RST;
      s_ff.rts_act  <= 1'b1;
      s_ff.rts_n    <= 1'b1;
      s_ff.fseq     <= UFC_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register

  assign avs_readdata_o    = s_ff.rdata;
  assign avs_waitrequest_o = !s_ff.wait_n;
  assign rts_n_o           = s_ff.rts_n;
  assign rx_store_o        = s_ff.rx_store;
  assign tx_pop_o          = s_ff.tx_pop;
  assign tx_start_o        = s_ff.tx_start;
  assign tx_char_o         = s_ff.tx_char;
  assign irq_o             = s_ff.irq;

endmodule : ufc_flow

// ==== bench/ufc_flow_checker.sv ====
// Port-level assertions for one flow control channel
`timescale 1ns/1ps
`include "ufc_cfg.svh"
module ufc_flow_checker (
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        cts_n_i,
  input wire logic        rts_n_o,
  input wire logic [6:0]  rx_level_i,
  input wire logic        rx_valid_i,
  input wire logic        rx_store_o,
  input wire logic        tx_fifo_valid_i,
  input wire logic        tx_pop_o,
  input wire logic        tx_start_o,
  input wire logic [7:0]  tx_char_o,
  input wire logic        irq_o
);
  logic [7:0] efr_ff, tcr_ff, ier_ff, fmt_ff;
  logic [6:0] hlv, rlv;
  logic       wdone;
  assign wdone = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign hlv   = {1'b0, tcr_ff[3:0], 2'b00};
  assign rlv   = {1'b0, tcr_ff[7:4], 2'b00};
  // Shadow of the control registers, so the checks know which mode is live
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      efr_ff <= 8'h00;
      tcr_ff <= 8'h00;
      ier_ff <= 8'h00;
      fmt_ff <= 8'h03;
    end else if (wdone) begin
      if (avs_address_i == `UFC_OFS_EFR) efr_ff <= avs_writedata_i[7:0];
      if (avs_address_i == `UFC_OFS_TCR) tcr_ff <= avs_writedata_i[7:0];
      if (avs_address_i == `UFC_OFS_IER) ier_ff <= avs_writedata_i[7:0];
      if (avs_address_i == `UFC_OFS_FMT) fmt_ff <= avs_writedata_i[7:0];
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  // Five samples cover the two-flop synchroniser plus the decision stage
  sequence s_cts_off;
    (efr_ff[7] && cts_n_i) [*5];
  endsequence
  AST_BUS_ACK: assert property (s_req |=> !avs_waitrequest_o) else $error("no bus answer");
  AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer longer than one cycle");
  AST_STORE_CAUSE: assert property (rx_store_o |-> $past(rx_valid_i))
    else $error("store without received char");
  AST_POP_START: assert property (tx_pop_o |-> tx_start_o && $past(tx_fifo_valid_i))
    else $error("pop without start or data");
  AST_CTS_GATE: assert property (s_cts_off |=> !tx_pop_o)
    else $error("data sent with CTS inactive");
  AST_RTS_HALT: assert property ((efr_ff[6] && rx_level_i >= hlv) [*4] |=> rts_n_o)
    else $error("RTS active at halt level");
  AST_RTS_RESUME: assert property
    ((efr_ff[6] && rx_level_i <= rlv && rx_level_i < hlv) [*4] |=> !rts_n_o)
    else $error("RTS inactive at resume level");
  AST_IRQ_MASK: assert property
    (irq_o |-> ier_ff[5] || ier_ff[7] || $past(ier_ff[5] || ier_ff[7]))
    else $error("interrupt while masked");
  AST_CHAR_TRIM: assert property
    (tx_start_o |-> (tx_char_o >> (fmt_ff[1:0] + 4'd5)) == 8'h00)
    else $error("char wider than word length");
endmodule : ufc_flow_checker
bind ufc_flow ufc_flow_checker i_ufc_flow_checker (.*);

// ==== bench/ufc_tx_model.sv ====
// Stand-in for the shifter: busy for one character time after each start
`timescale 1ns/1ps
module ufc_tx_model #(
  parameter int CHAR_CYC = 12
) (
  input  wire logic core_clk_i,
  input  wire logic resetn_i,
  input  wire logic tx_start_i,
  output logic      tx_busy_o
);
  int cnt;
  // Busy rises the cycle after a start, as the block expects of its shifter
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= 0;
    end else if (tx_start_i) begin
      cnt <= CHAR_CYC;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  assign tx_busy_o = (cnt != 0);
endmodule : ufc_tx_model

// ==== bench/ufc_flow_tb.sv ====
// Directed test of one flow control channel through its register bus
`timescale 1ns/1ps
`include "ufc_cfg.svh"
module ufc_flow_tb;
  logic        clk, rstn, rd, wr, cts, rxv, txv;
  logic        wreq, rts, st, pop, busy, start, irq, stv;
  logic [5:0]  addr;
  logic [31:0] wd, rdat;
  logic [3:0]  be;
  logic [6:0]  lvl;
  logic [7:0]  rxd, txd, ch, q;
  logic [7:0]  txq[$], e[$];
  int          bad_count, n_tests, i;
  ufc_flow i_ufc_flow (.core_clk_i(clk), .resetn_i(rstn), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .cts_n_i(cts), .rts_n_o(rts),
    .rx_level_i(lvl), .rx_valid_i(rxv), .rx_data_i(rxd), .rx_store_o(st),
    .tx_fifo_valid_i(txv), .tx_fifo_data_i(txd), .tx_pop_o(pop), .tx_busy_i(busy),
    .tx_start_o(start), .tx_char_o(ch), .irq_o(irq));
  ufc_tx_model #(.CHAR_CYC(12)) i_ufc_tx_model (.core_clk_i(clk), .resetn_i(rstn),
    .tx_start_i(start), .tx_busy_o(busy));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Record each started character; a pop empties our one-deep FIFO head
  always @(posedge clk) begin
    if (start === 1'b1) txq.push_back(ch);
    if (pop === 1'b1) txv <= 1'b0;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input bit ok, input string m);
    n_tests++;
    if (!ok) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  // Hold the request until waitrequest is seen low, then release
  task automatic bus(input bit w, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    addr <= a;
    wd   <= {24'h000000, d};
    wr   <= w;
    rd   <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 40) begin
      bad_count++;
      finish_test();
    end
    @(posedge clk);
  endtask : bus
  task automatic rdc(input logic [5:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h00);
    chk(q === x, "read value");
  endtask : rdc
  task automatic rx(input logic [7:0] d);
    rxd <= d;
    rxv <= 1'b1;
    @(posedge clk);
    rxv <= 1'b0;
    @(posedge clk);
    stv = st;
  endtask : rx
  task automatic wtx(input int n);
    for (int k = 0; k < 300 && txq.size() < n; k++) @(posedge clk);
    if (txq.size() < n) begin
      bad_count++;
      finish_test();
    end
  endtask : wtx
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rd, wr, rxv, txv, bad_count, n_tests} = '0;
    {addr, wd, lvl, rxd, txd} = '0;
    rstn = 1'b0;
    cts  = 1'b1;
    be   = 4'hf;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc(`UFC_OFS_FMT, 8'h03);
    rdc(`UFC_OFS_IIR, `UFC_IIR_NONE);
    rdc(6'h3c, 8'h00);
    be <= 4'h0;
    bus(1'b1, `UFC_OFS_EFR, 8'hff);
    be <= 4'hf;
    rdc(`UFC_OFS_EFR, 8'h00);
    chk(rts === 1'b1, "rts idle");
    // CTS ignored without auto-CTS, then throttles with it
    txd <= 8'h5a;
    txv <= 1'b1;
    wtx(1);
    bus(1'b1, `UFC_OFS_IER, 8'h80);
    bus(1'b1, `UFC_OFS_EFR, 8'h80);
    txd <= 8'ha5;
    txv <= 1'b1;
    repeat (30) @(posedge clk);
    chk(txq.size() == 1, "sent against CTS");
    cts <= 1'b0;
    wtx(2);
    cts <= 1'b1;
    repeat (8) @(posedge clk);
    chk(irq === 1'b0, "CTS irq in auto mode");
    bus(1'b1, `UFC_OFS_EFR, 8'h00);
    cts <= 1'b0;
    repeat (8) @(posedge clk);
    cts <= 1'b1;
    repeat (8) @(posedge clk);
    chk(irq === 1'b1, "CTS irq missing");
    rdc(`UFC_OFS_IIR, `UFC_IIR_CTS);
    bus(1'b1, `UFC_OFS_IER, 8'h20);
    $display("cts test done");
    // RTS hysteresis with halt 60 and resume 32
    bus(1'b1, `UFC_OFS_TCR, 8'h8f);
    bus(1'b1, `UFC_OFS_EFR, 8'h40);
    lvl <= 7'd59;
    repeat (6) @(posedge clk);
    chk(rts === 1'b0, "rts below halt");
    lvl <= 7'd60;
    repeat (6) @(posedge clk);
    chk(rts === 1'b1, "rts at halt");
    lvl <= 7'd40;
    repeat (6) @(posedge clk);
    chk(rts === 1'b1, "rts between levels");
    lvl <= 7'd32;
    repeat (6) @(posedge clk);
    chk(rts === 1'b0, "rts at resume");
    lvl <= 7'd0;
    $display("rts test done");
    bus(1'b1, `UFC_OFS_RES1, 8'h11);
    bus(1'b1, `UFC_OFS_RES2, 8'h13);
    bus(1'b1, `UFC_OFS_HALT1, 8'h19);
    bus(1'b1, `UFC_OFS_HALT2, 8'h17);
    // Sent flow characters for transmit modes 1 to 3
    for (i = 1; i < 4; i++) begin
      txq.delete();
      e.delete();
      if (i[1]) e.push_back(8'h19);
      if (i[0]) e.push_back(8'h17);
      if (i[1]) e.push_back(8'h11);
      if (i[0]) e.push_back(8'h13);
      bus(1'b1, `UFC_OFS_EFR, {4'h0, i[1:0], 2'b00});
      lvl <= 7'd60;
      wtx(e.size() / 2);
      lvl <= 7'd32;
      wtx(e.size());
      chk(txq == e, "flow chars sent");
      lvl <= 7'd0;
    end
    $display("send test done");
    // Received halt and resume for the first and second pair
    for (i = 1; i < 3; i++) begin
      bus(1'b1, `UFC_OFS_EFR, {6'h00, i[1:0]});
      rx(i[1] ? 8'h19 : 8'h17);
      chk(stv === 1'b0 && irq === 1'b1, "halt");
      txq.delete();
      txd <= 8'h3c;
      txv <= 1'b1;
      repeat (30) @(posedge clk);
      chk(txq.size() == 0, "sent while halted");
      rdc(`UFC_OFS_IIR, `UFC_IIR_HALT);
      rx(i[1] ? 8'h11 : 8'h13);
      chk(irq === 1'b0, "resume");
      wtx(1);
    end
    bus(1'b1, `UFC_OFS_EFR, 8'h03);
    rx(8'h19);
    chk(irq === 1'b0, "half sequence halted");
    rx(8'h17);
    chk(irq === 1'b1, "sequence halt");
    rx(8'h11);
    rx(8'h13);
    chk(irq === 1'b0, "sequence resume");
    bus(1'b1, `UFC_OFS_MCR, 8'h20);
    bus(1'b1, `UFC_OFS_EFR, 8'h02);
    rx(8'h19);
    rx(8'h41);
    chk(irq === 1'b0, "any char resume");
    $display("receive test done");
    // Special character flags but does not halt
    bus(1'b1, `UFC_OFS_MCR, 8'h00);
    bus(1'b1, `UFC_OFS_EFR, 8'h20);
    rx(8'h17);
    chk(stv === 1'b1 && irq === 1'b1, "special char");
    txq.delete();
    txd <= 8'hc3;
    txv <= 1'b1;
    wtx(1);
    rdc(`UFC_OFS_IIR, `UFC_IIR_HALT);
    chk(irq === 1'b0, "special irq kept");
    // Five-bit words trim the character
    bus(1'b1, `UFC_OFS_EFR, 8'h00);
    bus(1'b1, `UFC_OFS_FMT, 8'h00);
    txq.delete();
    txd <= 8'hff;
    txv <= 1'b1;
    wtx(1);
    chk(txq[0] === 8'h1f, "word trim");
    $display("special and trim test done");
    finish_test();
  end
endmodule : ufc_flow_tb
